/* design/touch_irq_regs.svh */
// Register offsets, field positions, reset values and counts of the interrupt status block
`ifndef TOUCH_IRQ_REGS_SVH
`define TOUCH_IRQ_REGS_SVH

// Register offsets on the serial register port
`define ADDR_IRQ_MASK      8'h22
`define ADDR_IRQ_SRC       8'h23
`define ADDR_STATUS        8'h24

// Reset values
`define IRQ_MASK_RESET     8'h08
`define IRQ_SRC_RESET      8'h00
`define RDATA_RESET        8'h00
`define UNMAPPED_RDATA     8'h00

// Number of interrupt sources, width of each register
`define NUM_SOURCES        8
`define REG_WIDTH          8

// Source flag and status bit positions (shared layout)
`define BIT_MOTOR_SHORT    7
`define BIT_NEAR_OBJECT    6
`define BIT_RESET_LATCHED  6
`define BIT_FAR_OR_SENSE   5
`define BIT_CALIB          4
`define BIT_CONVERSION     3
`define BIT_TOUCH          3
`define BIT_LIFT           2
`define BIT_HEAT_WARN      1
`define BIT_HEAT_ALARM     0

// Positions of the raw inputs inside the sampled status vector
`define IN_MOTOR_SHORT     0
`define IN_NEAR_OBJECT     1
`define IN_CALIB           2
`define IN_CONV_RUN        3
`define IN_CONV_PROX       4
`define IN_TOUCH           5
`define IN_HEAT_WARN       6
`define IN_HEAT_ALARM      7
`define NUM_INPUTS         8

`endif

/* design/touch_irq_pkg.sv */
// Types shared by the interrupt status block
package touch_irq_pkg;
    // One register byte
    typedef logic [7:0] reg8_t;
    // Which edge of a temperature status raises its flag
    typedef enum logic {EDGE_RISE, EDGE_FALL} edge_sel_t;
    // Event that raises the far/sense-done flag
    typedef enum logic {NEAR_EV_FAR, NEAR_EV_SENSE_DONE} near_ev_t;
endpackage

/* design/sampled_status_if.sv */
// Carrier for sampled status levels and their values one cycle earlier
`timescale 1ns/1ps
interface sampled_status_if #(
    parameter int WIDTH = 9
);
    logic [WIDTH-1:0] level;    // Synchronised current level
    logic [WIDTH-1:0] prev;     // Level one clock earlier

    modport producer (output level, output prev);
    modport consumer (input level, input prev);
endinterface

/* design/status_sampler.sv */
// Two-stage synchroniser for raw status levels plus a one-cycle history stage
`timescale 1ns/1ps
module status_sampler #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Raw levels from other parts of the chip
    input  wire logic [WIDTH-1:0] raw,
    // Sampled levels to the edge logic
    sampled_status_if.producer    smp
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("status_sampler needs at least one input");
        end
    endgenerate

    logic [WIDTH-1:0] meta;         // First stage, read only by the second
    logic [WIDTH-1:0] stable;       // Second stage, safe to decode
    logic [WIDTH-1:0] history;      // Stable level one clock earlier
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_stable;
    logic [WIDTH-1:0] next_history;

    // Shift the chain; the analog sources are not on our clock
    always_comb begin
        next_meta    = raw;
        next_stable  = meta;
        next_history = stable;
    end

    // Register stage; everything reads low after reset so no edge is invented
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta    <= '0;
            stable  <= '0;
            history <= '0;
        end else begin
            meta    <= next_meta;
            stable  <= next_stable;
            history <= next_history;
        end
    end

    assign smp.level = stable;
    assign smp.prev  = history;
endmodule

/* design/sticky_flag_bank.sv */
// Bank of sticky event flags; a set in the clearing cycle survives the clear
`timescale 1ns/1ps
module sticky_flag_bank #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Events and acknowledge
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             clear_all,
    // Latched flags
    output logic      [WIDTH-1:0] flags
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sticky_flag_bank needs at least one flag");
        end
    endgenerate

    logic [WIDTH-1:0] next_flags;   // Flag values for the next edge

    // Per-bit next value: set wins over clear so no event is lost
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            always_comb begin
                if (set_vec[i]) begin
                    next_flags[i] = 1'b1;
                end else if (clear_all) begin
                    next_flags[i] = 1'b0;
                end else begin
                    next_flags[i] = flags[i];
                end
            end
        end
    endgenerate

    // Flags start cleared
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule

/* design/touch_prox_irq_status_logic.sv */
// Interrupt mask, interrupt source flags and instantaneous status of the touch controller
`timescale 1ns/1ps
`include "touch_irq_regs.svh"

module touch_prox_irq_status_logic (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Register port from the serial interface decoder
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire touch_irq_pkg::reg8_t reg_wdata,
    output touch_irq_pkg::reg8_t      reg_rdata,
    output logic                      reg_rvalid,
    // Instantaneous status levels from the sensing blocks
    input  wire logic                 motor_short_now,
    input  wire logic                 near_object_now,
    input  wire logic                 calib_pending_now,
    input  wire logic                 conversion_running,
    input  wire logic                 conversion_is_prox,
    input  wire logic                 touch_down_now,
    input  wire logic                 heat_warn_now,
    input  wire logic                 heat_alarm_now,
    // Event selection settings held in other registers
    input  wire logic                 near_irq_event_select,
    input  wire logic                 touch_detect_mode,
    input  wire logic                 heat_warn_edge_select,
    input  wire logic                 heat_alarm_edge_select,
    // Interrupt to the host and flags for the auxiliary outputs
    output logic                      irq,
    output touch_irq_pkg::reg8_t      interrupt_source_flags
);
    import touch_irq_pkg::*;

    // Data path in short:
    // - status levels cross into this clock by two flops
    // - a history stage shows each edge for one clock
    // - edge pulses set sticky flags; a source read clears
    // - irq is the OR of the flags the mask lets through
    // Every output leaves a flop, so no decode glitch shows.
    // Limitation: the select inputs are not synchronised;
    // moving one while its level moves may cost an event.
    // Writes to the source or status offset are ignored.
    // Unmapped offsets read as zero.

    // The flags must fill exactly one register byte
    generate
        if (`NUM_SOURCES != `REG_WIDTH) begin : g_bad_layout
            $error("source count must match the register width");
        end
    endgenerate

    // True when the selected edge appears between prev and cur
    // Inputs are synchronised already, so one compare is safe
    function automatic logic edge_hit(input logic cur, input logic prv, input edge_sel_t sel);
        logic hit;
        hit = 1'b0;
        if (sel == EDGE_RISE) begin
            hit = cur & ~prv;
        end else begin
            hit = ~cur & prv;
        end
        return hit;
    endfunction

    // True when the register port addresses the given offset
    // One place for every strobe offset compare; the read mux uses its own case
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Sampled status levels
    sampled_status_if #(.WIDTH(`NUM_INPUTS)) smp ();

    // Sampler and event nets
    logic [`NUM_INPUTS-1:0] raw_status;     // Raw inputs packed for the sampler
    reg8_t                  set_vec;        // One-cycle event pulses per source
    reg8_t                  flags;          // Latched source flags
    // Host-visible state and next values
    reg8_t                  mask;           // Interrupt enable mask
    reg8_t                  next_mask;      // Mask after this clock
    logic                   reset_latched;  // Reset-occurred status bit
    logic                   next_reset_latched;
    // Read path and outputs
    reg8_t                  status_now;     // Live status byte as the host sees it
    reg8_t                  next_rdata;     // Read data for the next clock
    logic                   next_rvalid;
    logic                   next_irq;
    reg8_t                  next_src_out;
    // Port decode strobes
    logic                   src_read;       // Host reads the source register
    logic                   stat_read;      // Host reads the status register
    logic                   mask_write;     // Host writes the mask register
    // Conversion end tracking
    logic                   conv_fell;      // Conversion just finished
    logic                   conv_was_prox;  // The finished one was a proximity scan

    // Pack the raw levels in a fixed order
    // Order must match the IN_ positions
    always_comb begin
        raw_status                      = '0;
        raw_status[`IN_MOTOR_SHORT]     = motor_short_now;
        raw_status[`IN_NEAR_OBJECT]     = near_object_now;
        raw_status[`IN_CALIB]           = calib_pending_now;
        raw_status[`IN_CONV_RUN]        = conversion_running;
        raw_status[`IN_CONV_PROX]       = conversion_is_prox;
        raw_status[`IN_TOUCH]           = touch_down_now;
        raw_status[`IN_HEAT_WARN]       = heat_warn_now;
        raw_status[`IN_HEAT_ALARM]      = heat_alarm_now;
    end

    // Sensing blocks run off other timing, so every level is synchronised first
    // Two flops cost two clocks of latency
    status_sampler #(
        .WIDTH (`NUM_INPUTS)
    ) u_sampler (
        .clk   (clk),
        .rst_b (rst_b),
        .raw   (raw_status),
        .smp   (smp.producer)
    );

    // Register port decode
    // Strobes last as long as reg_rd; each clock of it clears once,
    // so a held reg_rd could clear an event unseen
    // Only full offset matches count as a hit
    always_comb begin
        src_read   = reg_rd & hits(reg_addr, `ADDR_IRQ_SRC);
        stat_read  = reg_rd & hits(reg_addr, `ADDR_STATUS);
        mask_write = reg_wr & hits(reg_addr, `ADDR_IRQ_MASK);
    end

    // End of a conversion; the kind is taken from the cycle before the fall,
    // since the kind input may drop together with the running level
    // A kind that changes mid-run is only read at the fall
    always_comb begin
        conv_fell     = edge_hit(smp.level[`IN_CONV_RUN], smp.prev[`IN_CONV_RUN], EDGE_FALL);
        conv_was_prox = smp.prev[`IN_CONV_PROX];
    end

    // Event detection per source
    // Pulses last one clock; shorter levels may be lost
    // Pin to flag takes three clocks, to the outputs four
    always_comb begin
        set_vec = '0;
        // Motor short appears
        set_vec[`BIT_MOTOR_SHORT] = edge_hit(smp.level[`IN_MOTOR_SHORT],
                                             smp.prev[`IN_MOTOR_SHORT], EDGE_RISE);

        // Object comes close
        set_vec[`BIT_NEAR_OBJECT] = edge_hit(smp.level[`IN_NEAR_OBJECT],
                                             smp.prev[`IN_NEAR_OBJECT], EDGE_RISE);

        // Object goes far, or a proximity scan finishes
        if (near_ev_t'(near_irq_event_select) == NEAR_EV_FAR) begin
            set_vec[`BIT_FAR_OR_SENSE] = edge_hit(smp.level[`IN_NEAR_OBJECT],
                                                  smp.prev[`IN_NEAR_OBJECT], EDGE_FALL);
        end else begin
            set_vec[`BIT_FAR_OR_SENSE] = conv_fell & conv_was_prox;
        end

        // Compensation completes
        set_vec[`BIT_CALIB] = edge_hit(smp.level[`IN_CALIB],
                                       smp.prev[`IN_CALIB], EDGE_FALL);

        // Touch down in pen-detect mode, else a touch conversion finishes
        if (touch_detect_mode) begin
            set_vec[`BIT_TOUCH] = edge_hit(smp.level[`IN_TOUCH],
                                           smp.prev[`IN_TOUCH], EDGE_RISE);
        end else begin
            set_vec[`BIT_TOUCH] = conv_fell & ~conv_was_prox;
        end

        // Pen lifted
        set_vec[`BIT_LIFT] = edge_hit(smp.level[`IN_TOUCH],
                                      smp.prev[`IN_TOUCH], EDGE_FALL);

        // Temperature thresholds, edge chosen by software
        set_vec[`BIT_HEAT_WARN] = edge_hit(smp.level[`IN_HEAT_WARN], smp.prev[`IN_HEAT_WARN],
                                           edge_sel_t'(heat_warn_edge_select));
        set_vec[`BIT_HEAT_ALARM] = edge_hit(smp.level[`IN_HEAT_ALARM], smp.prev[`IN_HEAT_ALARM],
                                            edge_sel_t'(heat_alarm_edge_select));
    end

    // Sticky source flags; a read acknowledges all of them at once
    // Set beats clear, so a read-cycle event survives
    // Flags latch even when masked, so polling works
    sticky_flag_bank #(
        .WIDTH (`NUM_SOURCES)
    ) u_flags (
        .clk       (clk),
        .rst_b     (rst_b),
        .set_vec   (set_vec),
        .clear_all (src_read),
        .flags     (flags)
    );

    // Live status byte; bits 7 and 5..0 are not latched
    // Shows the synchronised level, two clocks late,
    // so a read just after an edge may show the old one
    always_comb begin
        status_now                     = '0;
        status_now[`BIT_MOTOR_SHORT]   = smp.level[`IN_MOTOR_SHORT];
        status_now[`BIT_RESET_LATCHED] = reset_latched;
        status_now[`BIT_FAR_OR_SENSE]  = smp.level[`IN_NEAR_OBJECT];
        status_now[`BIT_CALIB]         = smp.level[`IN_CALIB];
        status_now[`BIT_CONVERSION]    = smp.level[`IN_CONV_RUN];
        status_now[`BIT_LIFT]          = smp.level[`IN_TOUCH];
        status_now[`BIT_HEAT_WARN]     = smp.level[`IN_HEAT_WARN];
        status_now[`BIT_HEAT_ALARM]    = smp.level[`IN_HEAT_ALARM];
    end

    // Mask and reset-latched next values
    always_comb begin
        next_mask          = mask;
        next_reset_latched = reset_latched;
        // Whole byte written at once; a write steers which flags reach irq
        // Writes to any other offset change nothing
        if (mask_write) begin
            next_mask = reg_wdata;
        end
        // Only a reset sets this bit, so reading it can simply clear it
        // Any later reset sets it again for the host
        if (stat_read) begin
            next_reset_latched = 1'b0;
        end
    end

    // Read data, answered one clock after the strobe
    // reg_rdata holds the last answer; reg_rvalid marks
    // the one clock in which it is fresh
    // A source read clears the flags at the answering edge
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata  = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_IRQ_MASK: begin
                    next_rdata = mask;
                end
                `ADDR_IRQ_SRC: begin
                    // Flags as they stood before this read clears them
                    next_rdata = flags;
                end
                `ADDR_STATUS: begin
                    next_rdata = status_now;
                end
                default: begin
                    next_rdata = `UNMAPPED_RDATA;
                end
            endcase
        end
    end

    // Interrupt and flag outputs; registered so they cannot glitch at the pin,
    // at the price of one extra clock of latency
    // A source read drops irq one clock after its answer
    always_comb begin
        next_irq     = |(flags & mask);
        next_src_out = flags;
    end

    // Register stage for control state and outputs
    // Mask comes up with only the touch enable set, and
    // the reset bit comes up set to report the reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask                   <= `IRQ_MASK_RESET;
            reset_latched          <= 1'b1;
            reg_rdata              <= `RDATA_RESET;
            reg_rvalid             <= 1'b0;
            irq                    <= 1'b0;
            interrupt_source_flags <= `IRQ_SRC_RESET;
        end else begin
            mask                   <= next_mask;
            reset_latched          <= next_reset_latched;
            reg_rdata              <= next_rdata;
            reg_rvalid             <= next_rvalid;
            irq                    <= next_irq;
            interrupt_source_flags <= next_src_out;
        end
    end
endmodule

/* bench/touch_irq_monitor.sv */
// Concurrent checks on the ports of the interrupt status block
`timescale 1ns/1ps
`include "touch_irq_regs.svh"
module touch_irq_monitor
    import touch_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire reg8_t      reg_rdata,
    input  wire logic       reg_rvalid,
    // Status levels and edge settings
    input  wire logic       motor_short_now,
    input  wire logic       near_object_now,
    input  wire logic       calib_pending_now,
    input  wire logic       touch_down_now,
    input  wire logic       heat_warn_now,
    input  wire logic       heat_alarm_now,
    input  wire logic       heat_warn_edge_select,
    input  wire logic       heat_alarm_edge_select,
    // Interrupt outputs
    input  wire logic       irq,
    input  wire reg8_t      interrupt_source_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A read inside the window could clear the flag before it shows
    sequence quiet5;
        !reg_rd [*5];
    endsequence
    AST_SHORT_RISE:
        assert property ($rose(motor_short_now) ##0 quiet5 |-> interrupt_source_flags[7])
        else $error("short rise left flag 7 clear");
    AST_NEAR_RISE:
        assert property ($rose(near_object_now) ##0 quiet5 |-> interrupt_source_flags[6])
        else $error("near rise left flag 6 clear");
    AST_CALIB_FALL:
        assert property ($fell(calib_pending_now) ##0 quiet5 |-> interrupt_source_flags[4])
        else $error("calibration end left flag 4 clear");
    AST_LIFT_FALL:
        assert property ($fell(touch_down_now) ##0 quiet5 |-> interrupt_source_flags[2])
        else $error("lift left flag 2 clear");
    AST_WARN_EDGE:
        assert property (($changed(heat_warn_now) && heat_warn_now != heat_warn_edge_select)
            ##0 quiet5 |-> interrupt_source_flags[1]) else $error("warning edge missed");
    AST_ALARM_EDGE:
        assert property (($changed(heat_alarm_now) && heat_alarm_now != heat_alarm_edge_select)
            ##0 quiet5 |-> interrupt_source_flags[0]) else $error("alarm edge missed");
    AST_IRQ_CAUSE:
        assert property (irq |-> interrupt_source_flags != 8'h00)
        else $error("interrupt with no flag set");
    AST_SRC_READ:
        assert property (reg_rd && reg_addr == `ADDR_IRQ_SRC |=>
            reg_rvalid && reg_rdata == interrupt_source_flags) else $error("source read data");
    AST_SHORT_STATUS:
        assert property ($stable(motor_short_now) [*3] ##0 (reg_rd && reg_addr == `ADDR_STATUS)
            |=> reg_rdata[7] == $past(motor_short_now)) else $error("short status bit");
    AST_TOUCH_STATUS:
        assert property ($stable(touch_down_now) [*3] ##0 (reg_rd && reg_addr == `ADDR_STATUS)
            |=> reg_rdata[2] == $past(touch_down_now)) else $error("touch status bit");
    // Main scenarios reached
    cover property (reg_rd && reg_addr == `ADDR_IRQ_SRC && interrupt_source_flags != 8'h00);
    cover property ($rose(irq));
    cover property ($fell(heat_warn_now) && heat_warn_edge_select);
endmodule

/* bench/host_reg_model.sv */
// Host side of the register port: single byte writes and reads
`timescale 1ns/1ps
module host_reg_model
    import touch_irq_pkg::*;
(
    // Clock
    input  wire logic  clk,
    // Requests toward the block
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output reg8_t      reg_wdata,
    // Answers from the block
    input  wire reg8_t reg_rdata,
    input  wire logic  reg_rvalid
);
    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released lines show inverted data so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input reg8_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // A source read is an acknowledge; the answer lands one edge later
    task automatic read_reg(input logic [7:0] a, output reg8_t d, output logic ok);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

/* bench/tb_touch_prox_irq_status_logic.sv */
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "touch_irq_regs.svh"
module tb_touch_prox_irq_status_logic;
    import touch_irq_pkg::*;
    localparam int TIMEOUT = 5000; // About fourteen times the expected run
    logic       clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    reg8_t      reg_wdata;
    reg8_t      reg_rdata;
    logic       reg_rvalid;
    logic       irq;
    reg8_t      isf;
    logic [7:0] sense; // short,near,calib,conv,prox,touch,warn,alarm from bit 0
    logic [3:0] sel;   // near event, touch mode, warn edge, alarm edge
    int         num_errors;
    int         comparisons;
    int         cycle_count;

    always #25 clk = ~clk;

    host_reg_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    touch_prox_irq_status_logic i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .motor_short_now(sense[0]), .near_object_now(sense[1]),
        .calib_pending_now(sense[2]), .conversion_running(sense[3]),
        .conversion_is_prox(sense[4]), .touch_down_now(sense[5]), .heat_warn_now(sense[6]),
        .heat_alarm_now(sense[7]), .near_irq_event_select(sel[0]),
        .touch_detect_mode(sel[1]), .heat_warn_edge_select(sel[2]),
        .heat_alarm_edge_select(sel[3]), .irq(irq), .interrupt_source_flags(isf));

    task automatic report_and_stop;
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input reg8_t seen, input reg8_t exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Read must answer with a valid pulse and the expected byte
    task automatic expect_reg(input logic [7:0] a, input reg8_t exp);
        reg8_t d;
        logic  ok;
        i_host.read_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask
    // Change one level, let it cross the sync chain, then acknowledge
    task automatic step(input int idx, input logic val, input reg8_t exp);
        @(negedge clk);
        sense[idx] = val;
        repeat (6) @(negedge clk);
        check(isf, exp);
        check({7'h00, irq}, {7'h00, |exp});
        expect_reg(`ADDR_IRQ_SRC, exp);
        repeat (2) @(negedge clk);
        check(isf, 8'h00);
    endtask

    task automatic t_reset_state;
        check(isf, 8'h00);
        expect_reg(`ADDR_IRQ_MASK, 8'h08);
        expect_reg(`ADDR_STATUS, 8'h40);
        expect_reg(`ADDR_STATUS, 8'h00);
        expect_reg(8'h30, 8'h00);
    endtask
    task automatic t_mask_access;
        i_host.write_reg(`ADDR_IRQ_MASK, 8'hA5);
        expect_reg(`ADDR_IRQ_MASK, 8'hA5);
        i_host.write_reg(`ADDR_IRQ_SRC, 8'hFF);
        expect_reg(`ADDR_IRQ_SRC, 8'h00);
        i_host.write_reg(`ADDR_IRQ_MASK, 8'hFF);
        expect_reg(`ADDR_IRQ_MASK, 8'hFF);
    endtask
    task automatic t_short;
        step(0, 1'b1, 8'h80);
        expect_reg(`ADDR_STATUS, 8'h80);
        step(0, 1'b0, 8'h00);
        expect_reg(`ADDR_STATUS, 8'h00);
    endtask
    task automatic t_near_calib;
        step(1, 1'b1, 8'h40);
        expect_reg(`ADDR_STATUS, 8'h20);
        step(1, 1'b0, 8'h20);
        step(2, 1'b1, 8'h00);
        expect_reg(`ADDR_STATUS, 8'h10);
        step(2, 1'b0, 8'h10);
    endtask
    task automatic t_touch_pen;
        sel[1] = 1'b1;
        step(5, 1'b1, 8'h08);
        expect_reg(`ADDR_STATUS, 8'h04);
        step(5, 1'b0, 8'h04);
    endtask
    // Conversion ends split by kind; a near fall and a touch-down must stay silent here
    task automatic t_conversion;
        sel = 4'h1;
        step(3, 1'b1, 8'h00);
        expect_reg(`ADDR_STATUS, 8'h08);
        step(3, 1'b0, 8'h08);
        step(4, 1'b1, 8'h00);
        step(3, 1'b1, 8'h00);
        step(3, 1'b0, 8'h20);
        step(4, 1'b0, 8'h00);
        step(1, 1'b1, 8'h40);
        step(1, 1'b0, 8'h00);
        step(5, 1'b1, 8'h00);
        step(5, 1'b0, 8'h04);
    endtask
    // Both temperature levels under both edge choices
    task automatic t_heat;
        for (int b = 0; b < 2; b++) begin
            for (int e = 0; e < 2; e++) begin
                sel[2 + b] = e[0];
                step(6 + b, 1'b1, e ? 8'h00 : (8'h02 >> b));
                step(6 + b, 1'b0, e ? (8'h02 >> b) : 8'h00);
            end
        end
    endtask
    // A masked flag still latches but raises no interrupt
    task automatic t_mask_gate;
        i_host.write_reg(`ADDR_IRQ_MASK, 8'h7F);
        @(negedge clk);
        sense[0] = 1'b1;
        repeat (6) @(negedge clk);
        check(isf, 8'h80);
        check({7'h00, irq}, 8'h00);
        i_host.write_reg(`ADDR_IRQ_MASK, 8'hFF);
        repeat (2) @(negedge clk);
        check({7'h00, irq}, 8'h01);
        step(0, 1'b0, 8'h80);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == TIMEOUT) begin
            num_errors++;
            report_and_stop;
        end
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        sense = 8'h00;
        sel = 4'h0;
        num_errors = 0;
        comparisons = 0;
        cycle_count = 0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_reset_state;
        t_mask_access;
        t_short;
        t_near_calib;
        t_touch_pen;
        t_conversion;
        t_heat;
        t_mask_gate;
        report_and_stop;
    end
endmodule

bind touch_prox_irq_status_logic touch_irq_monitor i_mon (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .motor_short_now(motor_short_now), .near_object_now(near_object_now),
    .calib_pending_now(calib_pending_now), .touch_down_now(touch_down_now),
    .heat_warn_now(heat_warn_now), .heat_alarm_now(heat_alarm_now),
    .heat_warn_edge_select(heat_warn_edge_select),
    .heat_alarm_edge_select(heat_alarm_edge_select), .irq(irq),
    .interrupt_source_flags(interrupt_source_flags));
